// ==== rtl/rmcs_blink_if.sv ====
// Run and lit signals between the controller and one indicator timer
`timescale 1ns/1ps
interface rmcs_blink_if;
    logic run;
    logic lit;
    modport ctrl (output run, input lit);
    modport blink (input run, output lit);
endinterface

// ==== rtl/rmcs_blinker.sv ====
// Indicator timer: on phase then off phase, repeating while run is high
`timescale 1ns/1ps
module rmcs_blinker #(
    parameter logic [31:0] ON_CYC = 32'h0000_0001,
    parameter logic [31:0] OFF_CYC = 32'h0000_0001
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Controller side
    rmcs_blink_if.blink bl
);
    typedef struct packed {
        logic active;
        logic lit;
        logic [31:0] cnt;
    } rmcs_blink_state_type;

    rmcs_blink_state_type st;
    rmcs_blink_state_type next_st;

    // Each start begins with a full on phase
    always_comb begin
        next_st = st;
        if (!bl.run) begin
            next_st = '0;
        end else if (!st.active) begin
            next_st.active = 1'b1;
            next_st.lit = 1'b1;
            next_st.cnt = '0;
        end else if (st.lit && st.cnt >= ON_CYC - 32'h1) begin
            next_st.lit = 1'b0;
            next_st.cnt = '0;
        end else if (!st.lit && st.cnt >= OFF_CYC - 32'h1) begin
            next_st.lit = 1'b1;
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + 32'h1;
        end
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign bl.lit = st.lit;
endmodule

// ==== rtl/rmcs_pkg.sv ====
// Constants for the rectifier management command and status block
// How it works
// - A block read starts with a byte count excluding the checksum.
// - Multi-byte analog values go out low byte first, then high byte.
// - Status read returns count 9, four status bytes, vout, iout, temp.
// - Four status and alarm registers; error bit 1 means alarm.
// - Checksum mismatch sets fault bit 7, command dropped, clear-flags resets.
// - Unsupported command sets fault bit 5 and raises alert; clear resets.
// - Out-of-range bit 1 holds while data is out of range.
// - Fault byte shows enable pin, high-line capacity and will-restart.
// - Failed isolation test sets fault bit 3 only, no internal fault.
// - Operating status byte layout from isolation ok down to output on.
// - Internal alarm byte layout from fan fault down to delivery fault.
// - Delivery fault when own current differs from share demand by >10 A.
// - Output alarm byte layout; overcurrent shuts down below 39 V.
// - Indicator test lights all four, 7 s on, 2 s off, until stopped.
// - Indicator test off turns the other three indicators off; the output indicator follows output state.
// - Removal indicator flashes 0.5 s on and off; off command stops it.
// - Write unlock opens upper EEPROM quarter after 10 ms; lock closes it.
// - In limit, output indicator blinks above 36 V; at or below, hiccup in restart mode.
// - Inhibit-restart latches off after OV, OT or OC shutdown.
// - Successful restart clears alarm bytes and sets restarted-ok.
// - Clear-faults clears isolation, restarted, invalid and checksum bits.
// - Operation data 0x80 turns output on, 0x00 turns it off.
package rmcs_pkg;
    // Clock and times
    localparam longint CLK_HZ = 250_000_000;
    localparam longint CYC_PER_MS = CLK_HZ / 1000;
    localparam longint TEST_ON_MS = 7000;
    localparam longint TEST_OFF_MS = 2000;
    localparam longint FLASH_MS = 500;
    localparam longint UNLOCK_MS = 10;
    localparam logic [31:0] TEST_ON_CYC = 32'(TEST_ON_MS * CYC_PER_MS);
    localparam logic [31:0] TEST_OFF_CYC = 32'(TEST_OFF_MS * CYC_PER_MS);
    localparam logic [31:0] FLASH_CYC = 32'(FLASH_MS * CYC_PER_MS);
    localparam logic [31:0] UNLOCK_CYC = 32'(UNLOCK_MS * CYC_PER_MS);

    // Command codes
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_CLEAR = 8'h03;
    localparam logic [7:0] CMD_READ_STATUS = 8'hD0;
    localparam logic [7:0] CMD_TEST_ON = 8'hD2;
    localparam logic [7:0] CMD_TEST_OFF = 8'hD3;
    localparam logic [7:0] CMD_REMOVAL_ON = 8'hD4;
    localparam logic [7:0] CMD_REMOVAL_OFF = 8'hD5;
    localparam logic [7:0] CMD_UNLOCK = 8'hD6;
    localparam logic [7:0] CMD_LOCK = 8'hD7;
    localparam logic [7:0] CMD_INHIBIT = 8'hD8;
    localparam logic [7:0] CMD_AUTO = 8'hD9;
    localparam logic [7:0] CMD_ISO_TEST = 8'hDA;
    localparam logic [7:0] OP_ON = 8'h80;
    localparam logic [7:0] OP_OFF = 8'h00;

    // Status read framing
    localparam logic [7:0] STATUS_COUNT = 8'h09;
    localparam logic [3:0] RD_LAST = 4'h8;
    localparam logic [3:0] RD_STEP = 4'h1;

    // Measurement scaling: vout 400 per volt, iout 5 per amp
    localparam int VOUT_M = 400;
    localparam int IOUT_M = 5;
    localparam logic [15:0] VOUT_BLINK_MIN = 16'(36 * VOUT_M);
    localparam logic [15:0] VOUT_OC_SHUT = 16'(39 * VOUT_M);
    localparam logic [7:0] SHARE_DIFF_MAX = 8'(10 * IOUT_M);

    // Output alarm bit positions
    localparam int OA_PLIMIT = 7;
    localparam int OA_OT_SHUT = 5;
    localparam int OA_OC = 3;
    localparam int OA_OV_SHUT = 2;

    // Pin group width and indicator masks
    localparam int PIN_W = 20;
    localparam logic [3:0] LEDS_ALL = 4'hF;
    localparam logic [3:0] LED_OUTPUT = 4'h1;
endpackage

// ==== rtl/rmcs_sync.sv ====
// Three-flop pin synchroniser with second and third flop agreement
`timescale 1ns/1ps
module rmcs_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Pins and synchronised levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    typedef struct packed {
        logic [W-1:0] ff1;
        logic [W-1:0] ff2;
        logic [W-1:0] ff3;
        logic [W-1:0] out;
    } rmcs_sync_state_type;

    rmcs_sync_state_type st;
    rmcs_sync_state_type next_st;

    // A bit only changes once two stages agree, filtering one-cycle glitches
    always_comb begin
        next_st = st;
        next_st.ff1 = async_i;
        next_st.ff2 = st.ff1;
        next_st.ff3 = st.ff2;
        next_st.out = (~(st.ff2 ^ st.ff3) & st.ff3) |
                      ((st.ff2 ^ st.ff3) & st.out);
    end

    // State register
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sync_o = st.out;
endmodule

// ==== rtl/rmcs_top.sv ====
// Rectifier vendor command handler, status registers and indicators
`timescale 1ns/1ps
module rmcs_top #(
    parameter logic [31:0] TEST_ON_CYC = rmcs_pkg::TEST_ON_CYC,
    parameter logic [31:0] TEST_OFF_CYC = rmcs_pkg::TEST_OFF_CYC,
    parameter logic [31:0] FLASH_CYC = rmcs_pkg::FLASH_CYC,
    parameter logic [31:0] UNLOCK_CYC = rmcs_pkg::UNLOCK_CYC
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Decoded transactions from the serial framing layer
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_has_data_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic cmd_pec_ok_i,
    // Block read byte stream
    input wire logic rd_next_i,
    output logic [7:0] rd_data_o,
    output logic rd_valid_o,
    output logic rd_last_o,
    // Asynchronous pins and monitor levels
    input wire logic enable_pin_i,
    input wire logic high_line_i,
    input wire logic iso_pass_i,
    input wire logic iso_fail_i,
    input wire logic range_bad_i,
    input wire logic [6:0] int_alarm_i,
    input wire logic [7:0] out_alarm_i,
    // Same-clock measurements
    input wire logic [15:0] vout_i,
    input wire logic [7:0] iout_i,
    input wire logic [7:0] temp_i,
    input wire logic [7:0] share_demand_i,
    // Power stage and indicators
    output logic power_on_o,
    output logic hiccup_o,
    output logic iso_start_o,
    output logic eeprom_wr_en_o,
    output logic smb_alert_o,
    output logic [3:0] front_leds_o,
    output logic removal_led_o
);
    typedef struct packed {
        logic off_cmd;
        logic latched;
        logic inhibit;
        logic test_on;
        logic rem_on;
        logic unlock;
        logic unlock_pend;
        logic [31:0] unlock_cnt;
        logic pec_err;
        logic bad_cmd;
        logic bad_data;
        logic iso_fail;
        logic iso_ok;
        logic restarted;
        logic iso_pass_q;
        logic iso_fail_q;
        logic on_q;
        logic hiccup;
        logic iso_start;
        logic [3:0] leds;
        logic [7:0] int_alarm;
        logic [7:0] out_alarm;
        logic rd_active;
        logic [3:0] rd_idx;
        logic [7:0] rd_data;
        logic [7:0][7:0] snap;
    } rmcs_state_type;

    rmcs_state_type st;
    rmcs_state_type next_st;

    logic [rmcs_pkg::PIN_W-1:0] pin_s;
    logic en_s;
    logic hl_s;
    logic ip_s;
    logic if_s;
    logic rb_s;
    logic [6:0] ia_s;
    logic [7:0] oa_s;
    logic pwr_on;
    logic shut_evt;
    logic pdf;
    logic [7:0] cur_diff;
    logic limit;
    logic [7:0] fault_byte;
    logic [7:0] oper_byte;

    rmcs_blink_if test_bl ();
    rmcs_blink_if rem_bl ();
    rmcs_blink_if out_bl ();

    // All pins share one synchroniser; a common delay keeps them aligned
    rmcs_sync #(
        .W(rmcs_pkg::PIN_W)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .async_i({enable_pin_i, high_line_i, iso_pass_i, iso_fail_i,
                  range_bad_i, int_alarm_i, out_alarm_i}),
        .sync_o(pin_s)
    );
    assign {en_s, hl_s, ip_s, if_s, rb_s, ia_s, oa_s} = pin_s;

    // Indicator timers
    rmcs_blinker #(
        .ON_CYC(TEST_ON_CYC),
        .OFF_CYC(TEST_OFF_CYC)
    ) u_test (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .bl(test_bl.blink)
    );
    rmcs_blinker #(
        .ON_CYC(FLASH_CYC),
        .OFF_CYC(FLASH_CYC)
    ) u_rem (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .bl(rem_bl.blink)
    );
    rmcs_blinker #(
        .ON_CYC(FLASH_CYC),
        .OFF_CYC(FLASH_CYC)
    ) u_out (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .bl(out_bl.blink)
    );

    // Timer requests
    assign test_bl.run = st.test_on;
    assign rem_bl.run = st.rem_on;
    assign limit = st.on_q & (oa_s[rmcs_pkg::OA_PLIMIT] | oa_s[rmcs_pkg::OA_OC]);
    assign out_bl.run = limit & (vout_i > rmcs_pkg::VOUT_BLINK_MIN);

    // Output runs when commanded, enable pin low and not latched off
    assign pwr_on = ~st.off_cmd & ~en_s & ~st.latched;

    // Shutdown causes; overcurrent only trips below its voltage floor
    assign shut_evt = oa_s[rmcs_pkg::OA_OT_SHUT] | oa_s[rmcs_pkg::OA_OV_SHUT] |
        (oa_s[rmcs_pkg::OA_OC] & (vout_i < rmcs_pkg::VOUT_OC_SHUT));

    // Own current against share demand, both in output current units
    assign cur_diff = (iout_i > share_demand_i) ? iout_i - share_demand_i :
                      share_demand_i - iout_i;
    assign pdf = cur_diff > rmcs_pkg::SHARE_DIFF_MAX;

    // Command fault byte, bit 7 down to bit 0
    assign fault_byte = {st.pec_err, ~st.inhibit, st.bad_cmd, hl_s,
                         st.iso_fail, st.restarted, st.bad_data | rb_s,
                         en_s};

    // Operating status byte; isolation failure never feeds internal fault
    assign oper_byte = {1'b0, st.iso_ok, |st.int_alarm,
                        st.latched | shut_evt, st.rem_on, |st.out_alarm,
                        st.test_on, st.on_q};

    // Next-state logic: clears first, hardware sets last so sets win
    always_comb begin
        next_st = st;
        next_st.iso_start = 1'b0;
        next_st.on_q = pwr_on;
        next_st.iso_pass_q = ip_s;
        next_st.iso_fail_q = if_s;

        // Successful restart wipes alarms and reports itself
        if (pwr_on && !st.on_q) begin
            next_st.int_alarm = '0;
            next_st.out_alarm = '0;
            next_st.restarted = 1'b1;
        end

        // Latch off on a protective shutdown when restart is inhibited
        if (st.inhibit && st.on_q && shut_evt) begin
            next_st.latched = 1'b1;
        end

        // Enable pin high releases the latch for a later restart
        if (en_s) begin
            next_st.latched = 1'b0;
        end

        // Unlock takes effect only after its delay
        if (st.unlock_pend) begin
            if (st.unlock_cnt >= UNLOCK_CYC - 32'h1) begin
                next_st.unlock_pend = 1'b0;
                next_st.unlock = 1'b1;
            end else begin
                next_st.unlock_cnt = st.unlock_cnt + 32'h1;
            end
        end

        // Block read stream advance
        if (st.rd_active && rd_next_i) begin
            if (st.rd_idx == rmcs_pkg::RD_LAST) begin
                next_st.rd_active = 1'b0;
                next_st.rd_idx = '0;
            end else begin
                next_st.rd_data = st.snap[3'(st.rd_idx)];
                next_st.rd_idx = st.rd_idx + rmcs_pkg::RD_STEP;
            end
        end

        // Command execution; a failed checksum only raises its flag
        if (cmd_valid_i) begin
            if (!cmd_pec_ok_i) begin
                next_st.pec_err = 1'b1;
            end else begin
                case (cmd_code_i)
                    rmcs_pkg::CMD_OPERATION: begin
                        if (cmd_has_data_i && cmd_data_i == rmcs_pkg::OP_ON) begin
                            next_st.off_cmd = 1'b0;
                        end else if (cmd_has_data_i &&
                                     cmd_data_i == rmcs_pkg::OP_OFF) begin
                            next_st.off_cmd = 1'b1;
                            next_st.latched = 1'b0;
                        end else begin
                            next_st.bad_data = 1'b1;
                        end
                    end
                    rmcs_pkg::CMD_CLEAR: begin
                        next_st.iso_ok = 1'b0;
                        next_st.iso_fail = 1'b0;
                        next_st.restarted = 1'b0;
                        next_st.bad_cmd = 1'b0;
                        next_st.bad_data = 1'b0;
                        next_st.pec_err = 1'b0;
                    end
                    rmcs_pkg::CMD_READ_STATUS: begin
                        // Snapshot so the bytes of one read are coherent
                        next_st.snap[0] = fault_byte;
                        next_st.snap[1] = oper_byte;
                        next_st.snap[2] = st.int_alarm;
                        next_st.snap[3] = st.out_alarm;
                        next_st.snap[4] = vout_i[7:0];
                        next_st.snap[5] = vout_i[15:8];
                        next_st.snap[6] = iout_i;
                        next_st.snap[7] = temp_i;
                        next_st.rd_data = rmcs_pkg::STATUS_COUNT;
                        next_st.rd_idx = '0;
                        next_st.rd_active = 1'b1;
                    end
                    rmcs_pkg::CMD_TEST_ON: begin
                        next_st.test_on = 1'b1;
                    end
                    rmcs_pkg::CMD_TEST_OFF: begin
                        next_st.test_on = 1'b0;
                    end
                    rmcs_pkg::CMD_REMOVAL_ON: begin
                        next_st.rem_on = 1'b1;
                    end
                    rmcs_pkg::CMD_REMOVAL_OFF: begin
                        next_st.rem_on = 1'b0;
                    end
                    rmcs_pkg::CMD_UNLOCK: begin
                        if (!st.unlock) begin
                            next_st.unlock_pend = 1'b1;
                            next_st.unlock_cnt = '0;
                        end
                    end
                    rmcs_pkg::CMD_LOCK: begin
                        next_st.unlock = 1'b0;
                        next_st.unlock_pend = 1'b0;
                    end
                    rmcs_pkg::CMD_INHIBIT: begin
                        next_st.inhibit = 1'b1;
                    end
                    rmcs_pkg::CMD_AUTO: begin
                        next_st.inhibit = 1'b0;
                    end
                    rmcs_pkg::CMD_ISO_TEST: begin
                        next_st.iso_start = 1'b1;
                    end
                    default: begin
                        next_st.bad_cmd = 1'b1;
                    end
                endcase
            end
        end

        // Hardware sets, applied after every clear
        if (ip_s && !st.iso_pass_q) begin
            next_st.iso_ok = 1'b1;
        end
        if (if_s && !st.iso_fail_q) begin
            next_st.iso_fail = 1'b1;
        end
        next_st.int_alarm = next_st.int_alarm | {ia_s, pdf};
        next_st.out_alarm = next_st.out_alarm | oa_s;

        // Hiccup only in restart mode and at or below the blink threshold
        next_st.hiccup = limit & ~st.inhibit &
                         (vout_i <= rmcs_pkg::VOUT_BLINK_MIN);

        // Test cycle overrides; otherwise output indicator follows state
        if (st.test_on) begin
            next_st.leds = test_bl.lit ? rmcs_pkg::LEDS_ALL : '0;
        end else if (!st.on_q) begin
            next_st.leds = '0;
        end else if (out_bl.run) begin
            next_st.leds = out_bl.lit ? rmcs_pkg::LED_OUTPUT : '0;
        end else begin
            next_st.leds = rmcs_pkg::LED_OUTPUT;
        end
    end

    // State register; reset leaves output commanded on and all flags clear
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign rd_data_o = st.rd_data;
    assign rd_valid_o = st.rd_active;
    assign rd_last_o = st.rd_active & (st.rd_idx == rmcs_pkg::RD_LAST);
    assign power_on_o = st.on_q;
    assign hiccup_o = st.hiccup;
    assign iso_start_o = st.iso_start;
    assign eeprom_wr_en_o = st.unlock;
    assign smb_alert_o = st.bad_cmd;
    assign front_leds_o = st.leds;
    assign removal_led_o = rem_bl.lit;
endmodule

// ==== rtl/rmcs_unused_guard_removed.sv ====
// Spare file, holds no logic

// ==== testbench/rmcs_host.sv ====
// Host model: commands and read acks
`timescale 1ns/1ps
module rmcs_host (
    // Clock
    input wire logic sys_clk_i,
    // Command transaction
    output logic cmd_valid_o = 1'b0,
    output logic [7:0] cmd_code_o = 8'h00,
    output logic cmd_has_data_o = 1'b0,
    output logic [7:0] cmd_data_o = 8'h00,
    output logic cmd_pec_ok_o = 1'b1,
    // Read stream
    output logic rd_next_o = 1'b0
);
    // One-cycle request; idle fields flip
    task automatic send(input logic [7:0] c, d, input logic h, p);
        cmd_code_o = c;
        cmd_data_o = d;
        cmd_has_data_o = h;
        cmd_pec_ok_o = p;
        cmd_valid_o = 1'b1;
        @(negedge sys_clk_i);
        cmd_valid_o = 1'b0;
        cmd_code_o = ~c;
        cmd_data_o = ~d;
        cmd_has_data_o = ~h;
        cmd_pec_ok_o = ~p;
    endtask
    // Acks n bytes; framing NAKs the PEC
    task automatic drain(input int n, input bit slow);
        for (int i = 0; i < n; i++) begin
            rd_next_o = 1'b1;
            @(negedge sys_clk_i);
            if (slow || i == n - 1) begin
                rd_next_o = 1'b0;
                if (i < n - 1) @(negedge sys_clk_i);
            end
        end
    endtask
endmodule

// ==== testbench/rmcs_props.sv ====
// Port-level checks
`timescale 1ns/1ps
module rmcs_props #(
    parameter logic [31:0] TEST_OFF_CYC = 32'h1,
    parameter logic [31:0] FLASH_CYC = 32'h1,
    parameter logic [31:0] UNLOCK_CYC = 32'h2
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    // Command and read stream
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_pec_ok_i,
    input wire logic rd_next_i,
    input wire logic [7:0] rd_data_o,
    input wire logic rd_valid_o,
    input wire logic rd_last_o,
    // Outputs under watch
    input wire logic eeprom_wr_en_o,
    input wire logic smb_alert_o,
    input wire logic [3:0] front_leds_o,
    input wire logic removal_led_o
);
    localparam int UNLO = UNLOCK_CYC - 1;
    localparam int TOFF = TEST_OFF_CYC;
    localparam int FL = FLASH_CYC;
    logic [31:0] gap_led;
    logic [31:0] gap_rem;
    logic ok;
    assign ok = cmd_valid_i && cmd_pec_ok_i;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // Dark cycles before each rise
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            gap_led <= 32'h0;
            gap_rem <= 32'h0;
        end else begin
            gap_led <= front_leds_o[3] ? 32'h0 : gap_led + 32'h1;
            gap_rem <= removal_led_o ? 32'h0 : gap_rem + 32'h1;
        end
    end
    sequence s_test_lit;
        ##[2:3] front_leds_o == 4'hF;
    endsequence
    sequence s_slow_open;
        ##UNLO !eeprom_wr_en_o ##[1:2] eeprom_wr_en_o;
    endsequence
    AST_ALERT_SET: assert property (
        ok && !(cmd_code_i inside {8'h01, 8'h03, 8'hD0, [8'hD2:8'hDA]})
        |=> smb_alert_o) else $error("alert missing");
    AST_PEC_QUIET: assert property (
        cmd_valid_i && !cmd_pec_ok_i && !smb_alert_o |=> !smb_alert_o)
        else $error("alert on reject");
    AST_COUNT_FIRST: assert property (
        ok && cmd_code_i == 8'hD0 && !rd_valid_o
        |=> rd_valid_o && rd_data_o == 8'h09) else $error("bad count byte");
    AST_READ_CLOSE: assert property (
        rd_valid_o && rd_last_o && rd_next_i |=> !rd_valid_o)
        else $error("stream open");
    AST_LED_TEST: assert property (
        ok && cmd_code_i == 8'hD2 |-> s_test_lit)
        else $error("test not lit");
    AST_LED_OFF: assert property (
        ok && cmd_code_i == 8'hD3 |-> ##3 front_leds_o[3:1] == 3'h0)
        else $error("test not off");
    AST_TEST_GAP: assert property (
        $rose(front_leds_o[3]) && gap_led <= TOFF + 4 |-> gap_led == TOFF)
        else $error("test dark length");
    AST_FLASH_GAP: assert property (
        $rose(removal_led_o) && gap_rem <= FL + 4 |-> gap_rem == FL)
        else $error("flash dark length");
    AST_UNLOCK: assert property (
        ok && cmd_code_i == 8'hD6 && !eeprom_wr_en_o |-> s_slow_open)
        else $error("unlock delay");
    AST_REJECT_KEEP: assert property (
        cmd_valid_i && !cmd_pec_ok_i && cmd_code_i == 8'hD7
        && eeprom_wr_en_o |=> eeprom_wr_en_o)
        else $error("reject acted");
endmodule

// ==== testbench/rmcs_top_bench.sv ====
// Self-checking bench for the command handler
`timescale 1ns/1ps
module rmcs_top_bench;
    localparam logic [31:0] TON = 32'hC;
    localparam logic [31:0] TOFF = 32'h8;
    localparam logic [31:0] FL = 32'hA;
    localparam logic [31:0] UNL = 32'h10;
    logic sys_clk = 1'b0, nrst = 1'b0, en_pin = 1'b0, hl = 1'b0;
    logic iso_ok = 1'b0, iso_bad = 1'b0, rng = 1'b0;
    logic cmd_valid, has, pec, rd_next, rd_valid, rd_last;
    logic pwr, hic, iso_st, wr_en, alert, rem;
    logic [3:0] leds;
    logic [6:0] ia = 7'h00;
    logic [7:0] oa = 8'h00, code, data, rd_data, iout, temp, share;
    logic [15:0] vout;
    logic [7:0] exp_q [$];
    int mismatches = 0, checks_done = 0, cycles = 0;
    rmcs_host u_rmcs_host (.sys_clk_i(sys_clk), .cmd_valid_o(cmd_valid),
        .cmd_code_o(code), .cmd_has_data_o(has), .cmd_data_o(data),
        .cmd_pec_ok_o(pec), .rd_next_o(rd_next));
    rmcs_top #(.TEST_ON_CYC(TON), .TEST_OFF_CYC(TOFF), .FLASH_CYC(FL),
        .UNLOCK_CYC(UNL)) u_rmcs_top (.sys_clk_i(sys_clk), .nrst_i(nrst),
        .cmd_valid_i(cmd_valid), .cmd_code_i(code), .cmd_has_data_i(has),
        .cmd_data_i(data), .cmd_pec_ok_i(pec), .rd_next_i(rd_next),
        .rd_data_o(rd_data), .rd_valid_o(rd_valid), .rd_last_o(rd_last),
        .enable_pin_i(en_pin), .high_line_i(hl), .iso_pass_i(iso_ok),
        .iso_fail_i(iso_bad), .range_bad_i(rng), .int_alarm_i(ia),
        .out_alarm_i(oa), .vout_i(vout), .iout_i(iout), .temp_i(temp),
        .share_demand_i(share), .power_on_o(pwr), .hiccup_o(hic),
        .iso_start_o(iso_st), .eeprom_wr_en_o(wr_en), .smb_alert_o(alert),
        .front_leds_o(leds), .removal_led_o(rem));
    // Clock and hang guard
    always #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    // Watcher: judge each acked byte
    always @(posedge sys_clk) begin
        if (rd_valid === 1'b1 && rd_next === 1'b1 && exp_q.size() > 0)
            check(rd_data, exp_q.pop_front());
    end
    task automatic check(input logic [7:0] got, input logic [7:0] want);
        checks_done++;
        if (got !== want) begin
            mismatches++;
            $display("BAD %0t: got %h want %h", $time, got, want);
        end
    endtask
    task automatic ck1(input logic got, input logic want);
        check({7'h00, got}, {7'h00, want});
    endtask
    task automatic conclude();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic cmd(input logic [7:0] k);
        u_rmcs_host.send(k, 8'h00, 1'b0, 1'b1);
    endtask
    // Fault byte from {pec, badcmd, isofail, restarted, range}
    function automatic logic [7:0] f2(input logic [4:0] v);
        return {v[4], 1'b1, v[3], hl, v[2], v[1], v[0], 1'b0};
    endfunction
    // Status read: note nine bytes, then drain
    task automatic rd(input logic [7:0] s2, s1, a2, a1, input bit slow);
        exp_q = {exp_q, 8'h09, s2, s1, a2, a1, vout[7:0], vout[15:8]};
        exp_q = {exp_q, iout, temp};
        cmd(8'hD0);
        u_rmcs_host.drain(9, slow);
        wt(2);
        check(8'(exp_q.size()), 8'h00);
    endtask
    initial begin
        void'($urandom(32'h4110));
        vout = 16'($urandom_range(24000, 16000));
        iout = 8'($urandom_range(200, 60));
        temp = 8'($urandom);
        share = iout;
        hl = 1'($urandom);
        wt(16);
        nrst = 1'b1;
        wt(20);
        rd(f2(5'b00010), 8'h01, 8'h00, 8'h00, 1'b0);
        cmd(8'h03);
        u_rmcs_host.send(8'hD2, 8'h00, 1'b0, 1'b0);
        cmd(8'h55);
        rng = 1'b1;
        wt(8);
        check({4'h0, leds}, 8'h01);
        ck1(alert, 1'b1);
        rd(f2(5'b11001), 8'h01, 8'h00, 8'h00, 1'b1);
        cmd(8'h03);
        wt(2);
        ck1(alert, 1'b0);
        rd(f2(5'b00001), 8'h01, 8'h00, 8'h00, 1'b0);
        rng = 1'b0;
        wt(8);
        cmd(8'h03);
        iso_ok = 1'b1;
        iso_bad = 1'b1;
        share = iout - 8'h32;
        wt(8);
        cmd(8'hDA);
        rd(f2(5'b00100), 8'h41, 8'h00, 8'h00, 1'b0);
        ia = 7'h40;
        oa = 8'h10;
        share = iout - 8'h33;
        wt(8);
        ia = 7'h00;
        oa = 8'h00;
        share = iout;
        wt(8);
        rd(f2(5'b00100), 8'h65, 8'h81, 8'h10, 1'b1);
        u_rmcs_host.send(8'h01, 8'h00, 1'b1, 1'b1);
        wt(4);
        ck1(pwr, 1'b0);
        wt(20);
        u_rmcs_host.send(8'h01, 8'h80, 1'b1, 1'b1);
        wt(8);
        ck1(pwr, 1'b1);
        rd(f2(5'b00110), 8'h41, 8'h00, 8'h00, 1'b0);
        cmd(8'hD2);
        wt(3);
        check({4'h0, leds}, 8'h0F);
        wt(45);
        cmd(8'hD3);
        wt(4);
        check({4'h0, leds}, 8'h01);
        cmd(8'hD4);
        wt(4);
        ck1(rem, 1'b1);
        wt(45);
        cmd(8'hD5);
        wt(4);
        ck1(rem, 1'b0);
        cmd(8'hD6);
        wt(19);
        ck1(wr_en, 1'b1);
        u_rmcs_host.send(8'hD7, 8'h00, 1'b0, 1'b0);
        wt(2);
        ck1(wr_en, 1'b1);
        cmd(8'hD7);
        wt(1);
        ck1(wr_en, 1'b0);
        cmd(8'hD8);
        oa = 8'h04;
        wt(10);
        ck1(pwr, 1'b0);
        oa = 8'h00;
        wt(10);
        ck1(pwr, 1'b0);
        en_pin = 1'b1;
        wt(20);
        en_pin = 1'b0;
        wt(10);
        ck1(pwr, 1'b1);
        cmd(8'hD9);
        oa = 8'h80;
        vout = 16'h2EE0;
        wt(10);
        ck1(hic, 1'b1);
        vout = 16'h5000;
        wt(6);
        ck1(hic, 1'b0);
        conclude();
    end
endmodule
bind rmcs_top rmcs_props #(.TEST_OFF_CYC(TEST_OFF_CYC), .FLASH_CYC(FLASH_CYC),
    .UNLOCK_CYC(UNLOCK_CYC)) u_rmcs_props (.sys_clk_i, .nrst_i, .cmd_valid_i,
    .cmd_code_i, .cmd_pec_ok_i, .rd_next_i, .rd_data_o, .rd_valid_o,
    .rd_last_o, .eeprom_wr_en_o, .smb_alert_o, .front_leds_o, .removal_led_o);
